/* inc/pwm_timer_defines.vh */
// Purpose: constants for the 8-bit pwm / interval timer
// Assumes: plain Verilog-2005 include, guarded
// Notes:   clock select codes, mode codes, reset values
`ifndef PWM_TIMER_DEFINES_VH
`define PWM_TIMER_DEFINES_VH

// ----------------------------------------
// count clock select codes
// ----------------------------------------
`define CLKSEL_DIV1      2'h0
`define CLKSEL_DIV16     2'h1
`define CLKSEL_DIV64     2'h2
`define CLKSEL_PWC       2'h3

// ----------------------------------------
// prescaler figures (instruction cycles)
// ----------------------------------------
`define PRESCALE_W       6
`define DIV16_MASK       6'h0f
`define DIV64_MASK       6'h3f

// ----------------------------------------
// mode bit values
// ----------------------------------------
`define MODE_INTERVAL    1'b0
`define MODE_PWM         1'b1

// ----------------------------------------
// reset values
// ----------------------------------------
`define COUNT_RESET      8'h00
`define COMPARE_RESET    8'hff
`define PIN_RESET        1'b0

`endif

/* core/count_clock_select.v */
// Purpose: make the one-cycle count enable from the selected source
// Assumes: inst_tick pulses once per instruction cycle; pwc_tick from same clock
// Notes:   prescaler only runs while counting so the first tick is a full period
`timescale 1ns/100ps
`include "pwm_timer_defines.vh"

module count_clock_select (
   // clock and reset
   input  wire       core_clk,
   input  wire       resetn,
   // control
   input  wire       run,
   input  wire [1:0] count_clock_select,
   // tick sources
   input  wire       inst_tick,
   input  wire       pwc_tick,
   // selected enable
   output reg        count_tick
);

   reg [`PRESCALE_W-1:0] prescale;

   // ----------------------------------------
   // prescaler
   // ----------------------------------------
   // cleared while stopped so every run starts from phase zero
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         prescale <= {`PRESCALE_W{1'b0}};
      end else if (!run) begin
         prescale <= {`PRESCALE_W{1'b0}};
      end else if (inst_tick) begin
         prescale <= prescale + 1'b1;
      end
   end

   // ----------------------------------------
   // selector
   // ----------------------------------------
   // one of four sources picked as enable
   always @* begin
      case (count_clock_select)
         `CLKSEL_DIV1:  count_tick = run & inst_tick;
         `CLKSEL_DIV16: count_tick = run & inst_tick & ((prescale & `DIV16_MASK) == `DIV16_MASK);
         `CLKSEL_DIV64: count_tick = run & inst_tick & (prescale == `DIV64_MASK);
         `CLKSEL_PWC:   count_tick = run & pwc_tick;
         default:       count_tick = 1'b0;
      endcase
   end

endmodule

/* core/pwm_interval_timer.v */
// Purpose: 8-bit timer, interval mode or pwm mode, with compare latch
// Assumes: control bits arrive as plain ports from the cpu side, same clock
// Notes:   match and overflow occur on count ticks; no bus; compare buffered in a latch
//
// Behaviour
// - one 8-bit timer, interval or pwm
// - four count clock sources selectable
// - counter increments on each selected tick
// - interval spans one to 256 ticks
// - compare latched at zero, match uses latch
// - interval match sets request, clears counter
// - interval match toggles pin when enabled
// - pwm output high until latched match
// - pwm output high again on overflow, except at compare 255 where match wins
// - pwm match no clear, no request
// - never request while pwm runs
// - pwm duty in 1/256 steps
// - interval requests repeat every interval
// - mode bit zero interval, one pwm
// - run starts; stop clears counter
// - flag set regardless; irq is flag and enable
// - new compare applies from next count zero only
`timescale 1ns/100ps
`include "pwm_timer_defines.vh"

module pwm_interval_timer #(
   parameter WIDTH = 8
) (
   // clock and reset
   input  wire             core_clk,
   input  wire             resetn,
   // control bits
   input  wire             mode_pwm,
   input  wire [1:0]       count_clock_select,
   input  wire             count_run,
   input  wire             output_pin_enable,
   input  wire             match_irq_enable,
   input  wire             flag_clear,
   // compare register write
   input  wire             compare_write,
   input  wire [WIDTH-1:0] compare_wdata,
   // tick sources
   input  wire             inst_tick,
   input  wire             pwc_tick,
   // status and outputs
   output reg              match_request_flag,
   output wire             timer_irq_line,
   output reg              timer_pin,
   output wire             timer_pin_oe,
   output reg  [WIDTH-1:0] count_value
);

   reg  [WIDTH-1:0] compare_value_reg;
   reg  [WIDTH-1:0] compare_latch;
   reg  [WIDTH-1:0] next_count;
   reg              next_pin;
   wire             count_tick;
   wire             match;
   wire             overflow;
   wire             interval_hit;

   // ----------------------------------------
   // count clock
   // ----------------------------------------
   count_clock_select u_sel (
      .core_clk           (core_clk),
      .resetn             (resetn),
      .run                (count_run),
      .count_clock_select (count_clock_select),
      .inst_tick          (inst_tick),
      .pwc_tick           (pwc_tick),
      .count_tick         (count_tick)
   );

   // ----------------------------------------
   // compare register and latch
   // ----------------------------------------
   // latch copies only at count zero, so a write mid-period waits
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         compare_value_reg <= `COMPARE_RESET;
         compare_latch     <= `COMPARE_RESET;
      end else begin
         if (compare_write)
            compare_value_reg <= compare_wdata;
         if (count_value == {WIDTH{1'b0}})
            compare_latch <= compare_write ? compare_wdata : compare_value_reg;
      end
   end

   // match against the latch, never the live register
   assign match        = count_tick & (count_value == compare_latch);
   assign overflow     = count_tick & (&count_value);
   assign interval_hit = match & (mode_pwm == `MODE_INTERVAL);

   // ----------------------------------------
   // counter
   // ----------------------------------------
   // interval clears on match; pwm wraps freely over 256 ticks
   always @* begin
      next_count = count_value;
      if (!count_run)
         next_count = `COUNT_RESET;
      else if (interval_hit)
         next_count = `COUNT_RESET;
      else if (count_tick)
         next_count = count_value + 1'b1;
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         count_value <= `COUNT_RESET;
      else
         count_value <= next_count;
   end

   // ----------------------------------------
   // output pin
   // ----------------------------------------
   // pwm: high on overflow, low on match (match wins at compare 255); a zero compare gives one tick high in 256
   always @* begin
      next_pin = timer_pin;
      if (mode_pwm == `MODE_PWM) begin
         if (!count_run)
            next_pin = 1'b1;
         else if (match)
            next_pin = 1'b0;
         else if (overflow)
            next_pin = 1'b1;
      end else if (interval_hit && output_pin_enable) begin
         next_pin = ~timer_pin;
      end
   end

   always @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         timer_pin <= `PIN_RESET;
      else
         timer_pin <= next_pin;
   end

   assign timer_pin_oe = output_pin_enable;

   // ----------------------------------------
   // request flag
   // ----------------------------------------
   // set beats clear so a match in the clearing cycle is kept
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         match_request_flag <= 1'b0;
      else if (interval_hit && count_run)
         match_request_flag <= 1'b1;
      else if (flag_clear)
         match_request_flag <= 1'b0;
   end

   assign timer_irq_line = match_request_flag & match_irq_enable;

endmodule

/* tb/pwm_timer_assertions.sv */
// Purpose: port checks of pwm_interval_timer
// Assumes: one clock, reset low active
// Notes:   bound after the module
`timescale 1ns/100ps
module pwm_timer_chk #(parameter WIDTH = 8) (
   // clock, reset and controls
   input wire logic             core_clk,
   input wire logic             resetn,
   input wire logic             mode_pwm,
   input wire logic             count_run,
   input wire logic             match_irq_enable,
   // outputs
   input wire logic             match_request_flag,
   input wire logic             timer_irq_line,
   input wire logic             timer_pin,
   input wire logic [WIDTH-1:0] count_value
);
   // reset drops every check in flight
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_irq; timer_irq_line == (match_request_flag && match_irq_enable); endproperty
   a_irq: assert property (p_irq) else $error("irq line");
   property p_stop; !count_run |=> count_value == 0; endproperty
   a_stop: assert property (p_stop) else $error("stop");
   property p_step; $changed(count_value) |-> count_value == 0 || count_value == $past(count_value) + 1'b1; endproperty
   a_step: assert property (p_step) else $error("step");
   property p_rise; $rose(match_request_flag) |-> count_value == 0 && $past(count_run) && !mode_pwm; endproperty
   a_rise: assert property (p_rise) else $error("match");
   property p_nreq; mode_pwm && !match_request_flag |=> !match_request_flag; endproperty
   a_nreq: assert property (p_nreq) else $error("pwm request");
   property p_tog; !mode_pwm && $changed(timer_pin) |-> count_value == 0; endproperty
   a_tog: assert property (p_tog) else $error("toggle");
   property p_wrap; mode_pwm && &$past(count_value) && count_value == 0 |-> timer_pin; endproperty
   a_wrap: assert property (p_wrap) else $error("wrap");
   // in pwm the counter never jumps back on a match
   property p_hold; mode_pwm && count_run && $past(count_run) && $changed(count_value)
      |-> count_value == $past(count_value) + 1'b1; endproperty
   a_hold: assert property (p_hold) else $error("pwm clear");
   c_flag: cover property ($rose(match_request_flag));
   c_fall: cover property (mode_pwm && $fell(timer_pin));
   c_wrap: cover property (mode_pwm && &$past(count_value) && count_value == 0);
endmodule
bind pwm_interval_timer pwm_timer_chk #(.WIDTH(WIDTH)) i_pwm_timer_chk (.*);

/* tb/tb_top.sv */
// Purpose: self-checking bench for pwm_interval_timer
// Assumes: inst_tick held high, one instruction tick per cycle
// Notes:   periods counted in clock cycles
`timescale 1ns/100ps
module tb_top;
   // drives and observed outputs
   reg core_clk = 0, resetn = 0, mode_pwm = 0, run = 0, ien = 0;
   reg fclr = 0, cwr = 0, pulse_width_count_timer = 0, p0, oe = 1;
   wire poe;
   reg [1:0] sel = 0;
   reg [7:0] wd = 0;
   wire flag, irq, pin;
   wire [7:0] cnt;
   integer cyc = 0, last, t, h, n, i, n_mismatch = 0, total_checks = 0;
   reg [1:0] sv [5] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
   reg [7:0] cv [5] = '{8'hff, 8'h01, 8'h02, 8'h01, 8'h02};
   integer ln [5] = '{1, 1, 16, 64, 3};
   pwm_interval_timer i_pwm_interval_timer (.core_clk(core_clk), .resetn(resetn), .mode_pwm(mode_pwm),
      .count_clock_select(sel), .count_run(run), .output_pin_enable(oe), .match_irq_enable(ien),
      .flag_clear(fclr), .compare_write(cwr), .compare_wdata(wd), .inst_tick(1'b1), .pwc_tick(pulse_width_count_timer),
      .match_request_flag(flag), .timer_irq_line(irq), .timer_pin(pin), .timer_pin_oe(poe), .count_value(cnt));
   always #25 core_clk = ~core_clk;
   always @(posedge core_clk) cyc <= cyc + 1;
   // pwc source ticks every third cycle; hang guard
   always @(posedge core_clk) begin
      #1;
      pulse_width_count_timer = (cyc % 3 == 0);
      if (cyc > 20000) begin
         n_mismatch = n_mismatch + 1;
         conclude;
      end
   end
   task tk;
      @(posedge core_clk) #1;
   endtask
   task chk(input ok, input string m);
      begin
         total_checks = total_checks + 1;
         if (!ok) begin
            n_mismatch = n_mismatch + 1;
            $display("mismatch %0t %0s", $time, m);
         end
      end
   endtask
   task wr(input [7:0] v);
      begin
         cwr = 1;
         wd = v;
         tk;
         cwr = 0;
      end
   endtask
   // stop, reconfigure, load compare while count is zero, run
   task start(input m, input [1:0] s, input [7:0] c);
      begin
         run = 0;
         tk;
         chk(cnt === 8'h00, "stop");
         mode_pwm = m;
         sel = s;
         fclr = 1;
         wr(c);
         fclr = 0;
         run = 1;
      end
   endtask
   // wait for a request, note its cycle, clear it
   task wf;
      begin
         n = 0;
         while (flag !== 1'b1 && n < 9000) begin
            tk;
            n = n + 1;
         end
         t = cyc;
         chk(irq === ien, "irq");
         fclr = 1;
         tk;
         fclr = 0;
      end
   endtask
   task wl(input v);
      begin
         n = 0;
         while (pin !== v && n < 600) begin
            tk;
            n = n + 1;
         end
      end
   endtask
   task conclude;
      begin
         if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial begin
      repeat (16) tk;
      resetn = 1;
      chk(cnt === 8'h00 && flag === 1'b0 && pin === 1'b0, "reset");
      // interval mode over every count source
      for (i = 0; i < 5; i = i + 1) begin
         ien = i[0];
         start(0, sv[i], cv[i]);
         wf;
         last = t;
         p0 = pin;
         wf;
         chk(t - last == (cv[i] + 1) * ln[i], "interval");
         chk(pin === ~p0 && poe === 1'b1, "toggle");
      end
      // pin enable low: no toggle on match, pin not driven
      oe = 0;
      start(0, 2'h0, 8'h01);
      wf;
      p0 = pin;
      wf;
      chk(pin === p0 && poe === 1'b0, "pin enable");
      oe = 1;
      // compare written mid-run waits for the next match
      start(0, 2'h0, 8'h02);
      wf;
      wr(8'h05);
      last = t;
      wf;
      chk(t - last == 3, "old compare");
      last = t;
      wf;
      chk(t - last == 6, "new compare");
      // pwm at compare zero and 128 (duty 1/256 and 129/256)
      for (i = 0; i < 256; i = i + 128) begin
         start(1, 2'h0, i[7:0]);
         wl(0);
         wl(1);
         wl(0);
         h = n;
         wl(1);
         chk(h == i + 1 && h + n == 256, "pwm");
         chk(flag === 1'b0, "pwm request");
      end
      conclude;
   end
endmodule
